// file: shared/pss_pkg.sv
// constants, carrier types and shared decoding for the synchronous burst memory port
// assumes a single clock and a far-side master that drives all inputs but output enable synchronously
package pss_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int ADDR_W = 21;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int SEED_W = 2;
    // depth actually stored behind the port, low address bits only
    localparam int MEM_AW = 10;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [ADDR_W-1:SEED_W] RST_ADDR_HI = 19'h00000;
    localparam logic [SEED_W-1:0] RST_BURST = 2'h0;
    localparam logic [DATA_W-1:0] RST_RDATA = 36'h000000000;
    localparam logic [LANES-1:0] ALL_LANES = 4'hf;
    localparam logic [LANES-1:0] NO_LANES = 4'h0;

    // ----------------------------------------
    // synchronous inputs from the bus master
    // ----------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic processor_address_strobe_n;
        logic controller_address_strobe_n;
        logic burst_advance_n;
        logic global_write_n;
        logic byte_write_gate_n;
        logic [LANES-1:0] byte_lane_write_select_n;
        logic chip_select_one_n;
        logic chip_select_two;
        logic chip_select_three_n;
    } pss_ctrl_t;

    // ----------------------------------------
    // all state of the port except the storage array
    // ----------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:SEED_W] addr_hi;
        logic [SEED_W-1:0] burst;
        logic selected;
        logic drive_ok;
        logic [DATA_W-1:0] rdata;
    } pss_state_t;

    // lanes written at an edge: global write wins, else gated byte selects
    function automatic logic [LANES-1:0] pss_lane_mask(input logic gw_n, input logic bwe_n,
                                                       input logic [LANES-1:0] bw_n);
        if (!gw_n) begin
            return ALL_LANES;
        end
        if (!bwe_n) begin
            return ~bw_n;
        end
        return NO_LANES;
    endfunction

endpackage

// file: verilog/pss_port.sv
// bus-side control of a pipelined burst static memory with a small storage array
// assumes clk_i at 10 MHz, inputs other than output enable synchronous to it, data pins resolved outside
//
// Behaviour
// (RL1) address captured only on a strobe with all three chip selects active
// (RL2) captured address seeds the two-bit burst counter from its low bits
// (RL3) each byte lane select writes its byte only when the byte gate is low
// (RL4) global write low writes every lane, ignoring lane selects and gate
// (RL5) master drives byte gate low with lane selects for a partial write
// (RL6) burst counter steps on each edge with burst advance sampled low; code does not step it on edges with a strobe
// (RL7) selected only for select one low, select two high, select three low
// (RL8) processor strobe ignored while chip select one is high
// (RL9) chip selects looked at only on edges that load a new address
// (RL10) output enable low drives data pins, high leaves them undriven
// (RL11) output enable acts combinationally, not at a clock edge
// (RL12) first read clock after deselect keeps data outputs disabled
// (RL13) with both strobes low only the processor strobe acts
// (RL14) burst advance makes the next burst address internally
// (RL15) read data comes from the address of the previous rising edge
// (RL16) no strobe and no advance holds the address and repeats the access
`timescale 1ns/100ps
module pss_port
    import pss_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire pss_ctrl_t ctrl_i,
    input wire logic output_enable_n_i,
    input wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_o
);

    // ----------------------------------------
    // storage and state
    // ----------------------------------------
    logic [DATA_W-1:0] mem [2**MEM_AW];
    pss_state_t st_reg;
    pss_state_t st_next;

    logic chips_ok;
    logic proc_take;
    logic ctrl_take;
    logic strobe;
    logic load;
    logic [MEM_AW-1:0] idx;
    logic [LANES-1:0] wmask;
    logic wr_en;
    logic rd_en;
    logic [DATA_W-1:0] rd_word;

    // ----------------------------------------
    // strobe and select decode
    // ----------------------------------------
    always_comb begin
        chips_ok = !ctrl_i.chip_select_one_n && ctrl_i.chip_select_two
                   && !ctrl_i.chip_select_three_n; // RL7
        proc_take = !ctrl_i.processor_address_strobe_n
                    && !ctrl_i.chip_select_one_n; // RL8
        ctrl_take = !ctrl_i.controller_address_strobe_n && !proc_take; // RL13
        strobe = proc_take || ctrl_take;
        load = strobe && chips_ok; // RL1 RL9
        idx = {st_reg.addr_hi[MEM_AW-1:SEED_W], st_reg.burst};
        wmask = pss_lane_mask(ctrl_i.global_write_n, ctrl_i.byte_write_gate_n,
                              ctrl_i.byte_lane_write_select_n); // RL3 RL4 RL5
        wr_en = st_reg.selected && !strobe && (wmask != NO_LANES);
        rd_en = st_reg.selected && !strobe && (wmask == NO_LANES);
        rd_word = mem[idx];
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.drive_ok = 1'b0;
        if (strobe) begin
            st_next.selected = chips_ok; // RL7 RL9
            if (load) begin
                st_next.addr_hi = ctrl_i.addr[ADDR_W-1:SEED_W]; // RL1
                st_next.burst = ctrl_i.addr[SEED_W-1:0]; // RL2
            end
        end else begin
            if (!ctrl_i.burst_advance_n) begin
                st_next.burst = st_reg.burst + 2'h1; // RL6 RL14
            end
            if (rd_en) begin
                st_next.rdata = rd_word; // RL15
                st_next.drive_ok = 1'b1; // RL12
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '{addr_hi: RST_ADDR_HI, burst: RST_BURST, selected: 1'b0,
                        drive_ok: 1'b0, rdata: RST_RDATA};
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // byte-lane writes into storage
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (wmask[l]) begin
                    mem[idx][l*LANE_W +: LANE_W] <= dq_i[l*LANE_W +: LANE_W]; // RL3 RL4
                end
            end
        end
    end

    // ----------------------------------------
    // data pins
    // ----------------------------------------
    assign dq_o = st_reg.rdata;
    // direction follows the enable without waiting for a clock edge
    assign dq_oe_o = !output_enable_n_i && st_reg.drive_ok; // RL10 RL11 RL12

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_LOAD_ADDR: assert property (load |=> st_reg.addr_hi == $past(ctrl_i.addr[ADDR_W-1:SEED_W]) // RL1
                                    && st_reg.selected)
        else $error("address not captured on a selected strobe");
    AST_SEED: assert property (load |=> st_reg.burst == $past(ctrl_i.addr[SEED_W-1:0])) // RL2
        else $error("burst counter not seeded from low address bits");
    AST_DESELECT: assert property (strobe && !chips_ok |=> !st_reg.selected // RL7
                                   && $stable(st_reg.addr_hi))
        else $error("bad chip select combination did not deselect");
    AST_CS1_IGNORE: assert property (!ctrl_i.processor_address_strobe_n // RL8
                                     && ctrl_i.chip_select_one_n
                                     && ctrl_i.controller_address_strobe_n
                                     |=> $stable(st_reg.selected) && $stable(st_reg.addr_hi))
        else $error("processor strobe acted with select one high");
    AST_PRIO: assert property (!ctrl_i.processor_address_strobe_n // RL13
                               && !ctrl_i.controller_address_strobe_n
                               && !ctrl_i.chip_select_one_n |-> proc_take && !ctrl_take)
        else $error("controller strobe acted beside processor strobe");
    AST_ADVANCE: assert property (!strobe && !ctrl_i.burst_advance_n // RL6
                                  |=> st_reg.burst == $past(st_reg.burst) + 2'h1
                                      && $stable(st_reg.addr_hi))
        else $error("burst counter did not step on advance");
    AST_HOLD: assert property (!strobe && ctrl_i.burst_advance_n // RL16
                               |=> $stable(st_reg.burst) && $stable(st_reg.addr_hi))
        else $error("address moved with no strobe and no advance");
    AST_GLOBAL: assert property (!ctrl_i.global_write_n |-> wmask == ALL_LANES) // RL4
        else $error("global write did not select every lane");
    AST_GATE: assert property (ctrl_i.global_write_n && ctrl_i.byte_write_gate_n // RL3
                               |-> !wr_en)
        else $error("byte write without the byte gate");
    AST_PIPE: assert property (rd_en |=> dq_o == $past(rd_word)) // RL15
        else $error("read data not from previous edge address");
    AST_FIRST_MASK: assert property ($rose(st_reg.selected) |-> !dq_oe_o) // RL12
        else $error("outputs driven on first clock after deselect");
    AST_OE_HIGH: assert property (output_enable_n_i |-> !dq_oe_o) // RL10
        else $error("data driven while output enable high");

    COV_BURST4: cover property (load ##1 (!strobe && !ctrl_i.burst_advance_n) [*3]);
    COV_WRITE: cover property (load ##1 wr_en ##1 wr_en);
    COV_READ_OUT: cover property (load ##1 rd_en ##1 dq_oe_o);
    COV_DESELECT: cover property (st_reg.selected ##1 strobe && !chips_ok);

endmodule

// file: verification/pss_far_end.sv
// far-side data wire model for the burst memory port
// assumes the bench drives write data and the port drives read data
`timescale 1ns/100ps
module pss_far_end
    import pss_pkg::*;
(
    input wire logic clk_i,
    input wire logic drive_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [DATA_W-1:0] dq_o_i,
    input wire logic dq_oe_i,
    output logic [DATA_W-1:0] dq_i_o
);
    // ----------------------------------------
    // wire resolution
    // ----------------------------------------
    logic [DATA_W-1:0] last_reg = '0;
    // plain always: the initial value above would be a second writer for always_ff
    always @(posedge clk_i) begin
        last_reg <= dq_i_o;
    end
    // undriven wire shows the inverse of its last level
    always_comb begin
        if (drive_i) begin
            dq_i_o = wdata_i;
        end else if (dq_oe_i) begin
            dq_i_o = dq_o_i;
        end else begin
            dq_i_o = ~last_reg;
        end
    end
endmodule

// file: verification/pipelined_sync_sram_bus_port_bench.sv
// self-checking bench for the burst memory port
// assumes inputs change at the falling clock edge, save output enable in the deselect test
`timescale 1ns/100ps
module pipelined_sync_sram_bus_port_bench
    import pss_pkg::*;
();
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic oe_n = 1'b0;
    logic mdrv = 1'b0;
    logic [DATA_W-1:0] mdat = '0;
    logic [DATA_W-1:0] dq_i;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe_o;
    pss_ctrl_t ctrl;
    int fails = 0;
    int checked = 0;
    pss_port dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl),
        .output_enable_n_i(oe_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
    pss_far_end far_u (.clk_i(clk_i), .drive_i(mdrv), .wdata_i(mdat), .dq_o_i(dq_o),
        .dq_oe_i(dq_oe_o), .dq_i_o(dq_i));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic pss_ctrl_t idle(input logic [ADDR_W-1:0] a);
        idle = '1;
        idle.addr = a;
        idle.chip_select_one_n = 1'b0;
        idle.chip_select_three_n = 1'b0;
    endfunction
    task automatic step(input pss_ctrl_t c, input logic drv, input logic [DATA_W-1:0] d);
        @(negedge clk_i);
        ctrl <= c;
        mdrv <= drv;
        mdat <= d;
        @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic burst_rw();
        pss_ctrl_t c;
        c = idle(21'h000104);
        c.processor_address_strobe_n = 1'b0;
        step(c, 1'b0, '0);
        chk("oe_strobe", 36'h0, 36'(dq_oe_o));
        c = idle(21'h000104);
        c.global_write_n = 1'b0;
        c.burst_advance_n = 1'b0;
        step(c, 1'b1, 36'h123456789);
        step(c, 1'b1, 36'h9abcdef01);
        c = idle(21'h000104);
        c.controller_address_strobe_n = 1'b0;
        step(c, 1'b0, '0);
        c.controller_address_strobe_n = 1'b1;
        c.burst_advance_n = 1'b0;
        step(c, 1'b0, '0);
        chk("rd0", 36'h123456789, dq_o);
        chk("oe_rd", 36'h1, 36'(dq_oe_o));
        step(c, 1'b0, '0);
        chk("rd1", 36'h9abcdef01, dq_o);
        c = idle(21'h000105);
        c.processor_address_strobe_n = 1'b0;
        step(c, 1'b0, '0);
        step(idle(21'h000105), 1'b0, '0);
        chk("seed", 36'h9abcdef01, dq_o);
        $display("test burst_rw done");
    endtask
    task automatic byte_lanes();
        pss_ctrl_t c;
        c = idle(21'h000208);
        c.processor_address_strobe_n = 1'b0;
        step(c, 1'b0, '0);
        c = idle(21'h000208);
        c.global_write_n = 1'b0;
        step(c, 1'b1, 36'h0);
        c.global_write_n = 1'b1;
        c.byte_write_gate_n = 1'b0;
        c.byte_lane_write_select_n = 4'ha;
        step(c, 1'b1, 36'hfffffffff);
        c.byte_write_gate_n = 1'b1;
        c.byte_lane_write_select_n = 4'h0;
        step(c, 1'b0, '0);
        chk("lanes", 36'h007fc01ff, dq_o);
        step(c, 1'b0, '0);
        chk("hold", 36'h007fc01ff, dq_o);
        $display("test byte_lanes done");
    endtask
    task automatic deselect();
        pss_ctrl_t c;
        c = idle(21'h000104);
        c.processor_address_strobe_n = 1'b0;
        c.chip_select_one_n = 1'b1;
        step(c, 1'b0, '0);
        @(negedge clk_i) oe_n = 1'b1;
        c = idle(21'h000104);
        c.chip_select_two = 1'b0;
        step(c, 1'b0, '0);
        chk("ignored", 36'h007fc01ff, dq_o);
        chk("oe_off", 36'h0, 36'(dq_oe_o));
        #10 oe_n = 1'b0;
        #1 chk("oe_async", 36'h1, 36'(dq_oe_o));
        c.controller_address_strobe_n = 1'b0;
        step(c, 1'b0, '0);
        step(idle(21'h000104), 1'b0, '0);
        chk("deselected", 36'h0, 36'(dq_oe_o));
        $display("test deselect done");
    endtask
    // ----------------------------------------
    // clock, watchdog, main
    // ----------------------------------------
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        fails++;
        results();
    end
    initial begin
        ctrl = idle(21'h000000);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i) rst_n_i = 1'b1;
        burst_rw();
        byte_lanes();
        deselect();
        results();
    end
endmodule
